// [verilog/msm_regs.sv]
// Status, station address, management and ring pointer registers of the MAC.
//
// Behaviour
// - Flag bit 3 sets on good transmit; write one clears; no reset.
// - Flag bit 2 sets on good receive; write one clears; no reset.
// - Flag bit 1 sets on failed transmit; write one clears; no reset.
// - Flag bit 0 sets on failed receive; write one clears; no reset.
// - High address bits 15-0 hold top two address bytes; not reset.
// - Low address bits 31-0 hold lower four address bytes; not reset.
// - Management bits 31-16 hold read result or write payload; not reset.
// - Port selector bits 15-11, register index bits 10-6; not reset.
// - Data-bad bit 4 is zero when read data valid after completion.
// - Active bit 3 high during operation, clears when link idle; resets zero.
// - No-link bit 2 set on completion of a read when no PHY answered; writes leave it zero.
// - Fetch-go bit 1 starts a read; result lands in data field.
// - Store-go bit 0 starts a write of the data field.
// - Transmit ring base from bits 31-10, 1 KiB aligned.
// - Ring slot bits 9-3 step by one per used descriptor; 2-0 read zero.
// - Receive ring base bits 31-10 joined with slot index locate descriptor.
// - Up to 32 PHYs with 32 sixteen-bit registers each.
`timescale 1ns/1ps

module msm_regs #(
	parameter int HALF_CYC = msm_pkg::MDC_HALF_CYC
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Peripheral register bus.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	// Packet events from the datapath, one-cycle pulses.
	input  wire logic        tx_done_ok,
	input  wire logic        tx_done_err,
	input  wire logic        rx_done_ok,
	input  wire logic        rx_done_err,
	// Descriptor use pulses from the DMA engines.
	input  wire logic        tx_slot_used,
	input  wire logic        rx_slot_used,
	// Address of the current descriptors for the DMA engines.
	output logic      [31:0] tx_desc_addr,
	output logic      [31:0] rx_desc_addr,
	// Station address for the receive filter.
	output logic      [47:0] station_addr,
	// Management link pins.
	output logic             mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe
);

	// Register contents.
	logic [3:0]  flags;
	logic [15:0] mac_hi;
	logic [31:0] mac_lo;
	logic [15:0] mg_data;
	logic [4:0]  mg_port_sel;
	logic [4:0]  mg_reg;
	logic        mg_data_bad;
	logic        mg_active;
	logic        mg_no_link;
	logic        mg_fetch_go;
	logic        mg_store_go;
	logic [21:0] tx_ring_base;
	logic [6:0]  tx_ring_slot;
	logic [21:0] rx_ring_base;
	logic [6:0]  rx_ring_slot;

	// Engine state.
	msm_pkg::msm_state_t state;
	logic [7:0]  div_cnt;
	logic        mdc_q;
	logic [6:0]  bit_cnt;
	logic [63:0] shreg;
	logic        is_read;
	logic [15:0] rd_shift;
	logic        ta_zero;
	logic [2:0]  mdio_sync;
	logic        mdio_q;
	logic        mdio_fit;

	logic wr_acc;
	logic start_op;

	// Every register answers in the access cycle, so no wait state is
	// ever inserted and ready stays high.
	assign wr_acc   = psel && penable && pwrite;
	assign pready   = 1'b1;
	// A start only counts while the link is idle; a start written during a
	// running frame would otherwise corrupt the address fields in flight.
	// Read wins when both start bits are written together.
	assign start_op = wr_acc && (paddr == msm_pkg::ADDR_MGMT) && !mg_active &&
		(pwdata[msm_pkg::MG_FETCH_GO] || pwdata[msm_pkg::MG_STORE_GO]);

	// Hit test of one register address, used by every write path except start_op.
	function automatic logic hit(input logic [31:0] a);
		hit = wr_acc && (paddr == a);
	endfunction : hit

	// End of one half period of the management clock.
	function automatic logic half_end(input logic [7:0] cnt);
		half_end = (cnt == 8'(HALF_CYC - 1));
	endfunction : half_end

	// Event flags carry no reset; a new event wins over a clear.
	// The event assignments come last so that a pulse landing in the
	// same cycle as a write-one clear is never lost by software.
	always_ff @(posedge mclk) begin
		if (hit(msm_pkg::ADDR_SRC_FLAGS)) begin
			flags <= flags & ~pwdata[3:0];
		end
		if (tx_done_ok) begin
			flags[msm_pkg::FLG_TX_OK] <= 1'b1;
		end
		if (rx_done_ok) begin
			flags[msm_pkg::FLG_RX_OK] <= 1'b1;
		end
		if (tx_done_err) begin
			flags[msm_pkg::FLG_TX_FAIL] <= 1'b1;
		end
		if (rx_done_err) begin
			flags[msm_pkg::FLG_RX_ERR] <= 1'b1;
		end
	end

	// Station address halves keep their value through reset.
	always_ff @(posedge mclk) begin
		if (hit(msm_pkg::ADDR_MAC_HIGH)) begin
			mac_hi <= pwdata[15:0];
		end
		if (hit(msm_pkg::ADDR_MAC_LOW)) begin
			mac_lo <= pwdata;
		end
	end
	assign station_addr = {mac_hi, mac_lo};

	// Ring pointers: software may rewrite, the DMA steps the slot.
	// A software write wins over a use pulse in the same cycle; the slot
	// wraps after its last value, so the ring holds 128 descriptors.
	always_ff @(posedge mclk) begin
		if (hit(msm_pkg::ADDR_TX_RING)) begin
			tx_ring_base <= pwdata[31:10];
			tx_ring_slot <= pwdata[9:3];
		end else if (tx_slot_used) begin
			tx_ring_slot <= tx_ring_slot + 7'h01;
		end
		if (hit(msm_pkg::ADDR_RX_RING)) begin
			rx_ring_base <= pwdata[31:10];
			rx_ring_slot <= pwdata[9:3];
		end else if (rx_slot_used) begin
			rx_ring_slot <= rx_ring_slot + 7'h01;
		end
	end
	assign tx_desc_addr = {tx_ring_base, tx_ring_slot, 3'h0};
	assign rx_desc_addr = {rx_ring_base, rx_ring_slot, 3'h0};

	// Management address fields; writes while busy are ignored to keep the
	// frame in flight consistent.
	always_ff @(posedge mclk) begin
		if (hit(msm_pkg::ADDR_MGMT) && !mg_active) begin
			mg_port_sel <= pwdata[15:11];
			mg_reg      <= pwdata[10:6];
		end
	end

	// Data field takes writes when idle and read data on completion.
	always_ff @(posedge mclk) begin
		if (hit(msm_pkg::ADDR_MGMT) && !mg_active) begin
			mg_data <= pwdata[31:16];
		end else if (state == msm_pkg::MSM_DONE && is_read) begin
			mg_data <= rd_shift;
		end
	end

	// Completion status, not reset.
	// During a write the station drives the turnaround itself, so the
	// PHY never answers and a missing link cannot be seen; a write is
	// therefore reported as linked. Only reads can detect a dead link.
	always_ff @(posedge mclk) begin
		if (state == msm_pkg::MSM_DONE) begin
			mg_no_link  <= is_read && !ta_zero;
			mg_data_bad <= is_read && !ta_zero;
		end
	end

	// Busy and start bits; start bits stay set until the frame ends.
	// Busy drops in the done cycle, when the last bit has left the pin
	// and the line is already released, so software sees an idle link.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mg_active   <= msm_pkg::MG_ACTIVE_RST;
			mg_fetch_go <= msm_pkg::MG_GO_RST;
			mg_store_go <= msm_pkg::MG_GO_RST;
		end else if (start_op) begin
			mg_active   <= 1'b1;
			mg_fetch_go <= pwdata[msm_pkg::MG_FETCH_GO];
			mg_store_go <= !pwdata[msm_pkg::MG_FETCH_GO] &&
				pwdata[msm_pkg::MG_STORE_GO];
		end else if (state == msm_pkg::MSM_DONE) begin
			mg_active   <= 1'b0;
			mg_fetch_go <= 1'b0;
			mg_store_go <= 1'b0;
		end
	end

	// Three-stage sampler for the incoming management data pin.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mdio_sync <= 3'h7;
		end else begin
			mdio_sync <= {mdio_sync[1:0], mdio_in};
		end
	end

	// Filtered data bit: a change counts only once the second and third
	// stages agree, so a single glitch near a sampling point is ignored.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mdio_q <= 1'b1;
		end else if (mdio_sync[1] == mdio_sync[2]) begin
			mdio_q <= mdio_sync[2];
		end
	end
	assign mdio_fit = (mdio_sync[1] == mdio_sync[2]) ? mdio_sync[2] : mdio_q;

	// Clock divider: runs only during a frame so MDC idles low.
	// Holding the clock still between frames keeps the PHY from seeing
	// stray edges; the cost is one half period of latency at each start.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			mdc_q   <= 1'b0;
		end else if (state != msm_pkg::MSM_SHIFT) begin
			div_cnt <= 8'h00;
			mdc_q   <= 1'b0;
		end else if (half_end(div_cnt)) begin
			div_cnt <= 8'h00;
			mdc_q   <= !mdc_q;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign mdc = mdc_q;

	// Frame bit map, counted from zero as the bits leave the pin:
	//   0-31   preamble, all ones.
	//   32-33  start pattern.
	//   34-35  opcode, one-zero for a read and zero-one for a write.
	//   36-40  port selector, most significant bit first.
	//   41-45  register index, most significant bit first.
	//   46-47  turnaround; on a read the line is released here and the
	//          PHY pulls bit 47 low to show that it is present.
	//   48-63  data, most significant bit first.
	// The data field is loaded at the done state of every read, so a read that
	// finds no PHY still loads the all-ones pattern of the pulled line;
	// the data-bad bit tells software not to trust it.
	//
	// Frame engine: preamble, start, opcode, addresses, turnaround, data.
	// Bits change after the falling edge; read bits are taken just before
	// the rising edge, which leaves room for the sampler's latency.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= msm_pkg::MSM_IDLE;
			bit_cnt  <= 7'h00;
			shreg    <= 64'h0;
			is_read  <= 1'b0;
			rd_shift <= 16'h0;
			ta_zero  <= 1'b0;
		end else begin
			unique case (state)
				msm_pkg::MSM_IDLE: begin
					if (start_op) begin
						is_read  <= pwdata[msm_pkg::MG_FETCH_GO];
						ta_zero  <= 1'b0;
						bit_cnt  <= 7'h00;
						shreg <= {32'hffffffff, 2'b01,
							pwdata[msm_pkg::MG_FETCH_GO] ? 2'b10 : 2'b01,
							pwdata[15:11], pwdata[10:6], 2'b10,
							pwdata[31:16]};
						state <= msm_pkg::MSM_SHIFT;
					end
				end
				msm_pkg::MSM_SHIFT: begin
					if (half_end(div_cnt) && !mdc_q) begin
						// Sample ahead of the rising edge.
						if (is_read && bit_cnt == 7'd47) begin
							ta_zero <= !mdio_fit;
						end
						if (is_read && bit_cnt >= 7'd48) begin
							rd_shift <= {rd_shift[14:0], mdio_fit};
						end
					end
					if (half_end(div_cnt) && mdc_q) begin
						shreg   <= {shreg[62:0], 1'b0};
						bit_cnt <= bit_cnt + 7'h01;
						if (bit_cnt == 7'(msm_pkg::MG_FRAME_BITS - 1)) begin
							state <= msm_pkg::MSM_DONE;
						end
					end
				end
				msm_pkg::MSM_DONE: begin
					state <= msm_pkg::MSM_IDLE;
				end
				default: begin
					state <= msm_pkg::MSM_IDLE;
				end
			endcase
		end
	end

	// Pin drive: released during read turnaround and data phase.
	assign mdio_out = shreg[63];
	assign mdio_oe  = (state == msm_pkg::MSM_SHIFT) &&
		!(is_read && bit_cnt >= 7'd46);

	// Read multiplexer; unmapped addresses read zero.
	// Reads have no side effect, so polling busy never disturbs a frame.
	always_comb begin
		prdata = 32'h0;
		unique case (paddr)
			msm_pkg::ADDR_SRC_FLAGS: prdata = {28'h0, flags};
			msm_pkg::ADDR_MAC_HIGH:  prdata = {16'h0, mac_hi};
			msm_pkg::ADDR_MAC_LOW:   prdata = mac_lo;
			msm_pkg::ADDR_MGMT:      prdata = {mg_data, mg_port_sel, mg_reg,
				1'b0, mg_data_bad, mg_active, mg_no_link,
				mg_fetch_go, mg_store_go};
			msm_pkg::ADDR_TX_RING:   prdata = tx_desc_addr;
			msm_pkg::ADDR_RX_RING:   prdata = rx_desc_addr;
			default:                 prdata = 32'h0;
		endcase
	end

endmodule : msm_regs

// [verilog/msm_pkg.sv]
// Package of register offsets, field positions and timing for the MAC register block.
package msm_pkg;

	// Register byte addresses on the peripheral bus.
	localparam logic [31:0] ADDR_SRC_FLAGS = 32'h80000e04;
	localparam logic [31:0] ADDR_MAC_HIGH  = 32'h80000e08;
	localparam logic [31:0] ADDR_MAC_LOW   = 32'h80000e0c;
	localparam logic [31:0] ADDR_MGMT      = 32'h80000e10;
	localparam logic [31:0] ADDR_TX_RING   = 32'h80000e14;
	localparam logic [31:0] ADDR_RX_RING   = 32'h80000e18;

	// Event flag positions in the source flag register.
	localparam int FLG_RX_ERR  = 0;
	localparam int FLG_TX_FAIL = 1;
	localparam int FLG_RX_OK   = 2;
	localparam int FLG_TX_OK   = 3;

	// Management register field positions.
	localparam int MG_STORE_GO  = 0;
	localparam int MG_FETCH_GO  = 1;
	localparam int MG_NO_LINK   = 2;
	localparam int MG_ACTIVE    = 3;
	localparam int MG_DATA_BAD  = 4;
	localparam int MG_REG_LO    = 6;
	localparam int MG_PORT_LO   = 11;
	localparam int MG_DATA_LO   = 16;

	// Ring pointer field positions.
	localparam int RING_SLOT_LO = 3;
	localparam int RING_BASE_LO = 10;

	// Reset values of the control bits that reset at all.
	localparam logic MG_ACTIVE_RST = 1'b0;
	localparam logic MG_GO_RST     = 1'b0;

	// Management clock: half period in ns and its cycle count at 50 MHz.
	localparam int MDC_HALF_NS   = 200;
	localparam int MCLK_MHZ      = 50;
	localparam int MDC_HALF_CYC  = (MDC_HALF_NS * MCLK_MHZ) / 1000;
	localparam int MG_FRAME_BITS = 64;

	// Management engine states, Gray coded along the frame.
	typedef enum logic [1:0] {
		MSM_IDLE = 2'b00,
		MSM_SHIFT = 2'b01,
		MSM_DONE = 2'b11
	} msm_state_t;

endpackage : msm_pkg

// [tb/msm_regs_props.sv]
// Port checker of the MAC register block.
`timescale 1ns/1ps
module msm_regs_props #(parameter int HALF_CYC = 10) (
	// Clock, reset and register bus.
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Pulses and outputs watched.
	input wire logic        tx_slot_used,
	input wire logic [31:0] tx_desc_addr,
	input wire logic [31:0] rx_desc_addr,
	input wire logic [47:0] station_addr,
	input wire logic        mdc
);
	logic wr, wr_low, wr_high, wr_tx, wr_rx, wr_mg;
	// Decoded writes; reads never change any register.
	assign wr = psel && penable && pwrite;
	assign wr_low = wr && paddr == msm_pkg::ADDR_MAC_LOW;
	assign wr_high = wr && paddr == msm_pkg::ADDR_MAC_HIGH;
	assign wr_tx = wr && paddr == msm_pkg::ADDR_TX_RING;
	assign wr_rx = wr && paddr == msm_pkg::ADDR_RX_RING;
	assign wr_mg = wr && paddr == msm_pkg::ADDR_MGMT;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_low_addr: assert property (wr_low |=>
		station_addr[31:0] == $past(pwdata)) else $error("low address lost");
	a_high_addr: assert property (wr_high |=>
		station_addr[47:32] == $past(pwdata[15:0])) else $error("high lost");
	a_tx_base: assert property (wr_tx |=>
		tx_desc_addr[31:10] == $past(pwdata[31:10])) else $error("tx base");
	a_rx_base: assert property (wr_rx |=>
		rx_desc_addr == {$past(pwdata[31:3]), 3'h0}) else $error("rx base");
	a_slot_step: assert property (tx_slot_used && !wr_tx |=>
		tx_desc_addr[9:3] == $past(tx_desc_addr[9:3]) + 7'h1)
		else $error("tx slot did not step");
	a_low_zero: assert property (tx_desc_addr[2:0] == 3'h0 &&
		rx_desc_addr[2:0] == 3'h0) else $error("ring low bits set");
	a_go_mdc: assert property (wr_mg && pwdata[1:0] != 2'h0
		&& !prdata[3] |-> ##[1:40] $rose(mdc)) else $error("no link clock");
	a_mdc_half: assert property ($rose(mdc) |-> mdc [*3])
		else $error("link clock high too short");
	c_fetch: cover property (wr_mg && pwdata[1]);
	c_store: cover property (wr_mg && pwdata[0]);
	c_wrap: cover property (tx_slot_used ##1 tx_desc_addr[9:3] == 7'h0);
endmodule : msm_regs_props

bind msm_regs msm_regs_props #(.HALF_CYC(HALF_CYC)) i_props (
	.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.tx_slot_used(tx_slot_used), .tx_desc_addr(tx_desc_addr),
	.rx_desc_addr(rx_desc_addr), .station_addr(station_addr), .mdc(mdc));

// [tb/msm_phy_model.sv]
// Management link partner: one PHY with 32 registers.
`timescale 1ns/1ps
module msm_phy_model #(parameter logic [4:0] PORT = 5'h1f) (
	// Link pins seen from the PHY.
	input  wire logic mdc,
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	input  wire logic alive,
	output logic      mdio_in
);
	logic [13:0] hdr = 14'h0;
	logic [13:0] nh;
	logic [15:0] mem [32];
	logic [15:0] sh;
	logic [4:0]  ra;
	logic        rd = 1'b0;
	logic        drv = 1'b0;
	logic        dbit = 1'b1;
	int          cnt = 0;
	// The line has a pull-up, so a released line reads one.
	assign mdio_in = mdio_oe ? mdio_out : (drv && rd ? dbit : 1'b1);
	assign nh = {hdr[12:0], mdio_in};
	// Start, opcode, port and register are taken on the rising clock.
	always @(posedge mdc) begin
		hdr <= nh;
		if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 0 && alive && mdio_oe && nh[13:12] == 2'h1 &&
			nh[11] != nh[10] && nh[9:5] == PORT) begin
			rd <= nh[11];
			ra <= nh[4:0];
			cnt <= 18;
		end
		if (cnt > 0 && cnt <= 16 && !rd)
			sh <= {sh[14:0], mdio_in};
		if (cnt == 1 && !rd)
			mem[ra] <= {sh[14:0], mdio_in};
		if (cnt == 1)
			rd <= 1'b0;
	end
	// Turnaround zero then data, MSB first, change on the falling clock.
	always @(negedge mdc) begin
		drv <= cnt > 0 && cnt < 18;
		dbit <= cnt == 17 ? 1'b0 : mem[ra][cnt - 1];
	end
endmodule : msm_phy_model

// [tb/msm_regs_tb_top.sv]
// Self-checking bench of the MAC register block.
`timescale 1ns/1ps
module msm_regs_tb_top;
	typedef struct {logic [31:0] a, d, e;} msm_row_t;
	logic        mclk, rst_n, psel, penable, pwrite, alive;
	logic        pready, mdc, mdio_in, mdio_out, mdio_oe;
	logic [31:0] paddr, pwdata, prdata, tx_desc_addr, rx_desc_addr, rv;
	logic [47:0] station_addr;
	logic [3:0]  ev;
	logic [1:0]  used;
	int          err_total = 0, comparisons = 0, cyc = 0;
	msm_row_t    rows [5];

	msm_regs #(.HALF_CYC(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .tx_done_ok(ev[3]),
		.rx_done_ok(ev[2]), .tx_done_err(ev[1]), .rx_done_err(ev[0]),
		.tx_slot_used(used[1]), .rx_slot_used(used[0]),
		.tx_desc_addr(tx_desc_addr), .rx_desc_addr(rx_desc_addr),
		.station_addr(station_addr), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe));
	msm_phy_model i_phy (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.alive(alive), .mdio_in(mdio_in));

	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// One bus cycle; the request holds until the edge that takes it.
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge mclk);
		{psel, penable, pwrite} <= {2'h3, w};
		{paddr, pwdata} <= {a, d};
		@(posedge mclk);
		rv = prdata;
		{psel, penable, pwrite} <= 3'h0;
	endtask : bus
	task automatic mgmt(input logic [31:0] v);
		bus(1'b1, msm_pkg::ADDR_MGMT, v);
		bus(1'b0, msm_pkg::ADDR_MGMT, 32'h0);
		chk("busy", 32'(rv[3]), 32'h1);
		for (int i = 0; i < 400 && rv[3] !== 1'b0; i++)
			bus(1'b0, msm_pkg::ADDR_MGMT, 32'h0);
	endtask : mgmt
	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// A hung link or bus loop ends the run as a failure.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		{rst_n, psel, penable, pwrite, ev, used, paddr, pwdata} = '0;
		alive = 1'b1;
		rows = '{'{msm_pkg::ADDR_MAC_HIGH, 32'hffffabcd, 32'h0000abcd},
			'{msm_pkg::ADDR_MAC_LOW, 32'h12345678, 32'h12345678},
			'{msm_pkg::ADDR_TX_RING, 32'hfffff3ff, 32'hfffff3f8},
			'{msm_pkg::ADDR_RX_RING, 32'h00002007, 32'h00002000},
			'{32'h80000e1c, 32'hffffffff, 32'h00000000}};
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		// Only the control bits reset; the rest wait for software.
		bus(1'b0, msm_pkg::ADDR_MGMT, 32'h0);
		chk("mgmt ctrl", rv & 32'hb, 32'h0);
		chk("link idle", {29'h0, pready, mdc, mdio_oe}, 32'h4);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			chk("readback", rv, rows[i].e);
		end
		chk("addr lo", station_addr[31:0], 32'h12345678);
		chk("addr hi", 32'(station_addr[47:32]), 32'habcd);
		@(posedge mclk);
		used <= 2'h3;
		@(posedge mclk);
		used <= 2'h1;
		@(posedge mclk);
		used <= 2'h0;
		@(posedge mclk);
		chk("tx wrap", tx_desc_addr, 32'hfffff000);
		chk("rx slot", rx_desc_addr, 32'h00002010);
		bus(1'b1, msm_pkg::ADDR_SRC_FLAGS, 32'hf);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			ev <= 4'h1 << i;
			@(posedge mclk);
			ev <= 4'h0;
			bus(1'b0, msm_pkg::ADDR_SRC_FLAGS, 32'h0);
			chk("event", rv & 32'hf, 32'h1 << i);
			bus(1'b1, msm_pkg::ADDR_SRC_FLAGS, 32'h1 << i);
		end
		bus(1'b0, msm_pkg::ADDR_SRC_FLAGS, 32'h0);
		chk("flags clear", rv & 32'hf, 32'h0);
		// Write then read back the top port and register of the range.
		mgmt(32'h5a3cffc1);
		chk("write link", rv & 32'h1c, 32'h0);
		mgmt(32'h0000ffc2);
		chk("phy read", rv & 32'hffffffdf, 32'h5a3cffc0);
		chk("phy fields", rv & 32'hffc0, 32'hffc0);
		chk("read link", rv & 32'h1c, 32'h0);
		alive <= 1'b0;
		mgmt(32'h0000ffc2);
		chk("no link", rv & 32'h1c, 32'h14);
		// Reset in mid frame must stop the link and clear busy at once.
		alive <= 1'b1;
		bus(1'b1, msm_pkg::ADDR_MGMT, 32'h0000ffc2);
		repeat (20) @(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b0, msm_pkg::ADDR_MGMT, 32'h0);
		chk("reset busy", rv & 32'hb, 32'h0);
		chk("reset link", {30'h0, mdc, mdio_oe}, 32'h0);
		conclude();
	end
endmodule : msm_regs_tb_top
